// File: common/tcs_pkg.sv
package tcs_pkg;

	// Clock rates
	localparam longint SYS_CLK_HZ = 10000000;
	localparam longint OSC_HZ = 20480000;
	localparam longint BP_CLK_HZ = 10240000;
	localparam int BP_DIV_HALF = int'(OSC_HZ / (2 * BP_CLK_HZ));

	// Reference rates in bits per second
	localparam longint RATE_T1_BPS = 1544000;
	localparam longint RATE_E1_BPS = 2048000;
	localparam longint RATE_BRI_BPS = 2560000;
	localparam logic [1:0] RATE_T1 = 2'h0;
	localparam logic [1:0] RATE_E1 = 2'h1;
	localparam logic [1:0] RATE_BRI = 2'h2;

	// Measurement window and word widths
	localparam int MEAS_EDGES_LOG2 = 10;
	localparam int CNT_W = 16;
	localparam int ERR_W = 17;
	localparam int DAC_W = 12;
	localparam logic [DAC_W-1:0] DAC_CENTER = 12'h800;
	localparam logic [DAC_W-1:0] DAC_MAX = 12'hFFF;
	localparam logic [DAC_W-1:0] STEP_TRACK = 12'h004;
	localparam logic [DAC_W-1:0] STEP_LOCK = 12'h001;
	localparam logic [ERR_W-1:0] LOCK_NEAR_CNT = 17'h00001;

	// Locking range in tenths of ppm
	localparam longint LOCK_PPM10_S3 = 46;
	localparam longint LOCK_PPM10_S4 = 500;

	function automatic logic [CNT_W-1:0] tcs_nominal(longint rate);
		return CNT_W'((OSC_HZ * (longint'(1) << MEAS_EDGES_LOG2) + rate / 2) / rate);
	endfunction : tcs_nominal

	function automatic logic [ERR_W-1:0] tcs_range(longint rate, longint ppm10);
		longint r;
		r = (longint'(tcs_nominal(rate)) * ppm10) / 10000000;
		if (r <= 1) begin
			r = 2;
		end
		return ERR_W'(r);
	endfunction : tcs_range

	localparam logic [CNT_W-1:0] NOM_T1 = tcs_nominal(RATE_T1_BPS);
	localparam logic [CNT_W-1:0] NOM_E1 = tcs_nominal(RATE_E1_BPS);
	localparam logic [CNT_W-1:0] NOM_BRI = tcs_nominal(RATE_BRI_BPS);
	localparam logic [ERR_W-1:0] RNG_T1_S3 = tcs_range(RATE_T1_BPS, LOCK_PPM10_S3);
	localparam logic [ERR_W-1:0] RNG_E1_S3 = tcs_range(RATE_E1_BPS, LOCK_PPM10_S3);
	localparam logic [ERR_W-1:0] RNG_BRI_S3 = tcs_range(RATE_BRI_BPS, LOCK_PPM10_S3);
	localparam logic [ERR_W-1:0] RNG_T1_S4 = tcs_range(RATE_T1_BPS, LOCK_PPM10_S4);
	localparam logic [ERR_W-1:0] RNG_E1_S4 = tcs_range(RATE_E1_BPS, LOCK_PPM10_S4);
	localparam logic [ERR_W-1:0] RNG_BRI_S4 = tcs_range(RATE_BRI_BPS, LOCK_PPM10_S4);

	// Timing
	localparam longint SWITCH_HOLDOFF_S = 10;
	localparam longint SWITCH_HOLDOFF_CYC = SWITCH_HOLDOFF_S * SYS_CLK_HZ;
	localparam longint FLASH_HZ = 1;
	localparam longint FLASH_HALF_CYC = SYS_CLK_HZ / (2 * FLASH_HZ);
	localparam longint REF_TIMEOUT_US = 2000;
	localparam longint REF_TIMEOUT_CYC = REF_TIMEOUT_US * SYS_CLK_HZ / 1000000;

	// Commands
	localparam logic [1:0] CMD_FREE_RUN = 2'h0;
	localparam logic [1:0] CMD_TRACK_PRI = 2'h1;
	localparam logic [1:0] CMD_TRACK_SEC = 2'h2;

	typedef enum logic [1:0] {
		ST_FREE_RUN,
		ST_TRACKING,
		ST_LOCKED,
		ST_HOLDOVER
	} tcs_state_e;

endpackage : tcs_pkg

// File: testbench/tcs_clock_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none

module tcs_clock_ctrl_bench
	import tcs_pkg::*;
;
	localparam longint HOLD = 2000;
	localparam longint FLASH = 20;
	localparam longint TMO = 14000;
	logic clk, osc, rst, ce, present, enable, s3, cmd_valid, pd_start, drift;
	logic pri, sec, pri_f, sec_f, bp, trk, locked, hold, sel, red, green, pd_done;
	logic [1:0] rate, cmd, run, fault;
	logic [DAC_W-1:0] dac;
	logic signed [ERR_W-1:0] phase, mon;
	int errors, n_tests;

	tcs_clock_ctrl #(.HOLDOFF_CYC(HOLD), .FLASH_CYC(FLASH), .TIMEOUT_CYC(TMO)) tcs_clock_ctrl_inst (
		.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_osc_clk(osc),
		.i_primary_reference_source(pri), .i_secondary_reference_source(sec),
		.i_pri_fault(pri_f), .i_sec_fault(sec_f), .i_present(present), .i_enable(enable),
		.i_stratum3(s3), .i_rate_sel(rate), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
		.i_pd_start(pd_start), .o_dac_word(dac), .o_bp_clk(bp), .o_tracking_mode(trk),
		.o_locked(locked), .o_holdover(hold), .o_sel_secondary(sel), .o_led_red(red),
		.o_led_green(green), .o_phase_diff(phase), .o_pd_done(pd_done), .o_mon_err(mon)
	);

	// Reference period matches the 2.0 Mb rate at the bench oscillator
	tcs_trunk_card_model #(.HALF_NS(625.0)) tcs_trunk_card_model_inst (
		.i_run(run), .i_fault(fault), .i_drift(drift), .o_pri(pri), .o_sec(sec),
		.o_pri_fault(pri_f), .o_sec_fault(sec_f)
	);

	always #50 clk = !clk;

	initial begin
		osc = 1'b0;
		#13;
		forever #62.5 osc = !osc;
	end

	task automatic end_sim();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic check(input logic seen, input logic exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic pick(input int k);
		case (k)
			0: return sel;
			1: return locked;
			2: return hold;
			3: return trk;
			4: return green;
			default: return pd_done;
		endcase
	endfunction : pick

	task automatic wait_on(input int k, input logic v, input int lim, output int n);
		n = 0;
		while (pick(k) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (pick(k) !== v) begin
			errors++;
			$display("unexpected timeout at %0t: seen %h expected %h", $time, pick(k), v);
			end_sim();
		end
	endtask : wait_on

	task automatic send(input logic [1:0] c);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
	endtask : send

	task automatic t_leds();
		repeat (4) @(negedge clk);
		check(red, 1'b1);
		check(green, 1'b0);
		@(posedge clk) present <= 1'b0;
		repeat (4) @(negedge clk);
		check(red || green, 1'b0);
		@(posedge clk);
		present <= 1'b1;
		enable <= 1'b1;
		repeat (5) @(negedge clk);
		check(green, 1'b1);
		check(trk, 1'b0);
		check(dac === DAC_CENTER, 1'b1);
	endtask : t_leds

	task automatic t_cmds();
		logic [1:0] cs [4];
		cs = '{CMD_TRACK_SEC, CMD_TRACK_PRI, 2'h3, CMD_FREE_RUN};
		for (int i = 0; i < 4; i++) begin
			send(cs[i]);
			check(trk, i < 2);
			check(i < 2 ? sel === (i == 0) : dac === DAC_CENTER, 1'b1);
		end
	endtask : t_cmds

	task automatic t_lock();
		int n;
		@(posedge clk) drift <= 1'b1;
		send(CMD_TRACK_PRI);
		check(sel, 1'b0);
		wait_on(4, 1'b0, 30000, n);
		wait_on(4, 1'b1, FLASH + 4, n);
		check(n >= FLASH - 1 && n <= FLASH + 1, 1'b1);
		check(trk && !locked && !hold, 1'b1);
		wait_on(1, 1'b1, 16000, n);
		repeat (2 * FLASH) @(negedge clk);
		check(green && trk, 1'b1);
	endtask : t_lock

	task automatic t_phase();
		int n;
		@(posedge clk) pd_start <= 1'b1;
		@(posedge clk) pd_start <= 1'b0;
		wait_on(5, 1'b1, 16000, n);
		check(phase >= -1 && phase <= 1, 1'b1);
		check(mon >= -2 && mon <= 2, 1'b1);
		@(negedge clk);
		check(pd_done, 1'b0);
	endtask : t_phase

	task automatic t_switch();
		int n;
		@(posedge clk) fault <= 2'b01;
		wait_on(0, 1'b1, 200, n);
		check(trk && !hold, 1'b1);
		@(posedge clk) fault <= 2'b00;
		wait_on(0, 1'b0, 40000, n);
		check(n >= HOLD - 4, 1'b1);
	endtask : t_switch

	task automatic t_holdover();
		int n;
		logic [DAC_W-1:0] d;
		@(posedge clk) run <= 2'b00;
		wait_on(2, 1'b1, 40000, n);
		check(trk, 1'b1);
		d = dac;
		repeat (100) @(negedge clk);
		check(dac === d, 1'b1);
		@(posedge clk) run <= 2'b11;
	endtask : t_holdover

	task automatic t_free();
		int n;
		@(posedge clk) fault <= 2'b11;
		wait_on(3, 1'b0, 50, n);
		check(dac === DAC_CENTER, 1'b1);
		send(CMD_FREE_RUN);
		@(posedge clk) fault <= 2'b00;
		repeat (200) @(negedge clk);
		check(trk, 1'b0);
	endtask : t_free

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		present = 1'b1;
		enable = 1'b0;
		s3 = 1'b0;
		rate = RATE_E1;
		cmd_valid = 1'b0;
		cmd = CMD_FREE_RUN;
		pd_start = 1'b0;
		drift = 1'b0;
		run = 2'b11;
		fault = 2'b00;
		errors = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_leds();
		t_cmds();
		t_lock();
		t_phase();
		t_switch();
		t_holdover();
		t_free();
		end_sim();
	end
endmodule : tcs_clock_ctrl_bench

`default_nettype wire

// File: testbench/tcs_clock_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none

module tcs_clock_ctrl_sva
	import tcs_pkg::*;
#(
	parameter longint FLASH_CYC = FLASH_HALF_CYC
) (
	// Clocks and reset
	input wire logic i_clk,
	input wire logic i_osc_clk,
	input wire logic i_sys_rst,
	// Inputs
	input wire logic i_ce,
	input wire logic i_pri_fault,
	input wire logic i_sec_fault,
	input wire logic i_present,
	input wire logic i_enable,
	input wire logic i_cmd_valid,
	input wire logic [1:0] i_cmd,
	// Outputs
	input wire logic [DAC_W-1:0] o_dac_word,
	input wire logic o_bp_clk,
	input wire logic o_tracking_mode,
	input wire logic o_locked,
	input wire logic o_holdover,
	input wire logic o_sel_secondary,
	input wire logic o_led_red,
	input wire logic o_led_green,
	input wire logic signed [ERR_W-1:0] o_phase_diff,
	input wire logic o_pd_done
);
	logic trk;
	logic steady;
	logic [31:0] flash_cnt_ff;
	assign trk = o_tracking_mode && !o_locked && !o_holdover;
	assign steady = !o_tracking_mode || o_locked;

	// Cycles since the indicator last changed while tracking
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			flash_cnt_ff <= 32'h0;
		end else if (!trk || $changed(o_led_green)) begin
			flash_cnt_ff <= 32'h0;
		end else begin
			flash_cnt_ff <= flash_cnt_ff + 32'h1;
		end
	end

	sequence s_ready;
		(i_present && i_enable && !i_pri_fault && !i_sec_fault)[*4];
	endsequence

	property p_red_disabled;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_present && !i_enable)[*3] |-> o_led_red && !o_led_green;
	endproperty
	a_red_disabled: assert property (p_red_disabled) else $error("red not lit");

	property p_dark_absent;
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_present)[*3] |-> !o_led_red && !o_led_green;
	endproperty
	a_dark_absent: assert property (p_dark_absent) else $error("indicator lit");

	property p_green_steady;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_present && i_enable)[*4] ##0 (steady && $past(steady)) |-> o_led_green;
	endproperty
	a_green_steady: assert property (p_green_steady) else $error("green not steady");

	property p_flash;
		@(posedge i_clk) disable iff (i_sys_rst)
		flash_cnt_ff <= 32'(FLASH_CYC);
	endproperty
	a_flash: assert property (p_flash) else $error("green not flashing");

	property p_cmd_free;
		@(posedge i_clk) disable iff (i_sys_rst)
		s_ready ##0 (i_cmd_valid && i_ce && i_cmd == CMD_FREE_RUN) |=> !o_tracking_mode;
	endproperty
	a_cmd_free: assert property (p_cmd_free) else $error("free run not entered");

	property p_cmd_pri;
		@(posedge i_clk) disable iff (i_sys_rst)
		s_ready ##0 (i_cmd_valid && i_ce && i_cmd == CMD_TRACK_PRI)
		|=> o_tracking_mode && !o_sel_secondary;
	endproperty
	a_cmd_pri: assert property (p_cmd_pri) else $error("primary not tracked");

	property p_both_fault;
		@(posedge i_clk) disable iff (i_sys_rst)
		$rose(i_pri_fault && i_sec_fault) |-> ##[1:20] !o_tracking_mode;
	endproperty
	a_both_fault: assert property (p_both_fault) else $error("no free run on loss");

	property p_modes;
		@(posedge i_clk) disable iff (i_sys_rst)
		!(o_locked && o_holdover) && (o_tracking_mode || !(o_locked || o_holdover));
	endproperty
	a_modes: assert property (p_modes) else $error("mode flags clash");

	property p_free_dac;
		@(posedge i_clk) disable iff (i_sys_rst)
		!o_tracking_mode |-> o_dac_word == DAC_CENTER;
	endproperty
	a_free_dac: assert property (p_free_dac) else $error("tuning moved in free run");

	property p_hold_dac;
		@(posedge i_clk) disable iff (i_sys_rst)
		o_holdover && $past(o_holdover) |-> $stable(o_dac_word);
	endproperty
	a_hold_dac: assert property (p_hold_dac) else $error("tuning moved in holdover");

	property p_phase;
		@(posedge i_clk) disable iff (i_sys_rst)
		$changed(o_phase_diff) |-> o_pd_done;
	endproperty
	a_phase: assert property (p_phase) else $error("phase changed unannounced");

	property p_bp_clk;
		@(posedge i_osc_clk) disable iff (i_sys_rst)
		i_ce[*4] |=> $changed(o_bp_clk);
	endproperty
	a_bp_clk: assert property (p_bp_clk) else $error("backplane clock stalled");

	c_locked: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_locked));
	c_holdover: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_holdover));
	c_switch: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_sel_secondary));
	c_pd: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_pd_done);
endmodule : tcs_clock_ctrl_sva

bind tcs_clock_ctrl tcs_clock_ctrl_sva #(.FLASH_CYC(FLASH_CYC)) tcs_clock_ctrl_sva_inst (
	.i_clk(i_clk), .i_osc_clk(i_osc_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
	.i_pri_fault(i_pri_fault), .i_sec_fault(i_sec_fault), .i_present(i_present),
	.i_enable(i_enable), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
	.o_dac_word(o_dac_word), .o_bp_clk(o_bp_clk), .o_tracking_mode(o_tracking_mode),
	.o_locked(o_locked), .o_holdover(o_holdover), .o_sel_secondary(o_sel_secondary),
	.o_led_red(o_led_red), .o_led_green(o_led_green), .o_phase_diff(o_phase_diff),
	.o_pd_done(o_pd_done)
);

`default_nettype wire

// File: testbench/tcs_trunk_card_model.sv
`timescale 1ns/100ps
`default_nettype none

module tcs_trunk_card_model #(
	parameter realtime HALF_NS = 625.0
) (
	// Control from bench
	input wire logic [1:0] i_run,
	input wire logic [1:0] i_fault,
	input wire logic i_drift,
	// Recovered references and loss flags
	output logic o_pri,
	output logic o_sec,
	output logic o_pri_fault,
	output logic o_sec_fault
);
	// Loss flags follow the bench
	assign o_pri_fault = i_fault[0];
	assign o_sec_fault = i_fault[1];

	int n_rise = 0;

	// Primary reference, stops while lost
	initial begin
		o_pri = 1'b0;
		forever begin
			#(HALF_NS);
			if (i_run[0] && !i_fault[0]) begin
				o_pri = !o_pri;
				n_rise += int'(o_pri);
			end
			// One late edge makes one window two counts longer
			if (i_drift && o_pri && n_rise == 1024) begin
				#250;
			end
		end
	end

	// Secondary reference, own phase
	initial begin
		o_sec = 1'b0;
		#(HALF_NS / 3.0);
		forever begin
			#(HALF_NS);
			if (i_run[1] && !i_fault[1]) begin
				o_sec = !o_sec;
			end
		end
	end
endmodule : tcs_trunk_card_model

`default_nettype wire

// File: verilog/tcs_clock_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Lock to reference, output 10.24 MHz backplane clock
// - Two references: primary and secondary
// - Recover 1.5, 2.0 and 2.56 Mb rates
// - Exactly one mode: tracking or free-run
// - Track frequency, then lock with fine steps
// - Drift drops lock to tracking, relocks
// - Unstable reference keeps tracking, not a fault
// - Free-run ignores references, uses own oscillator
// - Free-run on double fault or command
// - Steady red when installed but disabled
// - Steady green when locked or free-running
// - Flashing green while tracking
// - Dark only when not installed
// - Firmware-triggered phase difference measurement
// - Phase difference gives frequency and jitter figures
// - Lock range 4.6 ppm or 50 ppm; code uses 2 counts for every rate and grade
// - Monitor loop on the unused reference
// - Automatic switchover and recovery, no chatter
// - Switch on out-of-spec, holdover if both
// - At least 10 s between automatic switchovers; leaving holdover or free-run skips the holdoff
// - Free-run after enable and after command
module tcs_clock_ctrl
	import tcs_pkg::*;
#(
	parameter longint HOLDOFF_CYC = SWITCH_HOLDOFF_CYC,
	parameter longint FLASH_CYC = FLASH_HALF_CYC,
	parameter longint TIMEOUT_CYC = REF_TIMEOUT_CYC
) (
	// System clock domain
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Oscillator (link) clock domain
	input wire logic i_osc_clk,
	// Reference pins
	input wire logic i_primary_reference_source,
	input wire logic i_secondary_reference_source,
	input wire logic i_pri_fault,
	input wire logic i_sec_fault,
	// Board straps and switch
	input wire logic i_present,
	input wire logic i_enable,
	input wire logic i_stratum3,
	input wire logic [1:0] i_rate_sel,
	// Firmware commands
	input wire logic i_cmd_valid,
	input wire logic [1:0] i_cmd,
	input wire logic i_pd_start,
	// Oscillator tuning and backplane
	output logic [DAC_W-1:0] o_dac_word,
	output logic o_bp_clk,
	// Status
	output logic o_tracking_mode,
	output logic o_locked,
	output logic o_holdover,
	output logic o_sel_secondary,
	output logic o_led_red,
	output logic o_led_green,
	// Phase measurement
	output logic signed [ERR_W-1:0] o_phase_diff,
	output logic o_pd_done,
	output logic signed [ERR_W-1:0] o_mon_err
);

	tcs_state_e state_ff;
	logic [1:0] fault_s1_ff, fault_s2_ff;
	logic [2:0] pin_s1_ff, pin_s2_ff;
	logic present, enabled, stratum3;
	logic enable_d_ff;
	logic [1:0] rate_s1_ff, rate_s2_ff;
	logic free_cmd_ff;
	logic primary_reference_source_sec_ff;
	logic sel_sec_ff;
	logic [31:0] holdoff_ff;
	logic holdoff_done;
	logic [31:0] flash_cnt_ff;
	logic flash_ff;
	logic pd_arm_ff;
	logic signed [ERR_W-1:0] phase_ff;
	logic pd_done_ff;
	logic [1:0] ce_osc_ff;
	logic [BP_DIV_HALF-1:0] bp_cnt_ff;
	logic bp_clk_ff;
	logic [CNT_W-1:0] nominal;
	logic [ERR_W-1:0] range;
	logic [CNT_W-1:0] per_p, per_s;
	logic tgl_p, tgl_s;
	logic signed [ERR_W-1:0] err_p, err_s;
	logic new_p, new_s, spec_p, spec_s, near_p, near_s;
	logic [DAC_W-1:0] dac_p, dac_s;
	logic ok_p, ok_s, act_ok, oth_ok, primary_reference_source_ok;
	logic both_fault, act_near, locked;
	logic hold_p, hold_s, center;

	// Pin synchronisers in the system domain
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fault_s1_ff <= 2'h0;
			fault_s2_ff <= 2'h0;
			pin_s1_ff <= 3'h0;
			pin_s2_ff <= 3'h0;
			rate_s1_ff <= 2'h0;
			rate_s2_ff <= 2'h0;
		end else begin
			fault_s1_ff <= {i_sec_fault, i_pri_fault};
			fault_s2_ff <= fault_s1_ff;
			pin_s1_ff <= {i_stratum3, i_enable, i_present};
			pin_s2_ff <= pin_s1_ff;
			rate_s1_ff <= i_rate_sel;
			rate_s2_ff <= rate_s1_ff;
		end
	end

	assign present = pin_s2_ff[0];
	assign enabled = pin_s2_ff[0] & pin_s2_ff[1];
	assign stratum3 = pin_s2_ff[2];

	// Nominal count and locking range per rate and grade
	always_comb begin
		case (rate_s2_ff)
			RATE_T1: begin
				nominal = NOM_T1;
				range = stratum3 ? RNG_T1_S3 : RNG_T1_S4;
			end
			RATE_BRI: begin
				nominal = NOM_BRI;
				range = stratum3 ? RNG_BRI_S3 : RNG_BRI_S4;
			end
			default: begin
				nominal = NOM_E1;
				range = stratum3 ? RNG_E1_S3 : RNG_E1_S4;
			end
		endcase
	end

	// Clock enable carried into the oscillator domain
	always_ff @(posedge i_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ce_osc_ff <= 2'h0;
		end else begin
			ce_osc_ff <= {ce_osc_ff[0], i_ce};
		end
	end

	// Backplane clock from the steered oscillator
	always_ff @(posedge i_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			bp_cnt_ff <= '0;
			bp_clk_ff <= 1'b0;
		end else if (ce_osc_ff[1]) begin
			if (bp_cnt_ff == BP_DIV_HALF'(BP_DIV_HALF - 1)) begin
				bp_cnt_ff <= '0;
				bp_clk_ff <= ~bp_clk_ff;
			end else begin
				bp_cnt_ff <= bp_cnt_ff + 1'b1;
			end
		end
	end

	// One meter per reference, both always running
	tcs_ref_meter u_meter_pri (
		.i_osc_clk(i_osc_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(ce_osc_ff[1]),
		.i_ref(i_primary_reference_source),
		.o_period(per_p),
		.o_tgl(tgl_p)
	);

	tcs_ref_meter u_meter_sec (
		.i_osc_clk(i_osc_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(ce_osc_ff[1]),
		.i_ref(i_secondary_reference_source),
		.o_period(per_s),
		.o_tgl(tgl_s)
	);

	// Loop of the unselected reference only monitors
	assign center = (state_ff == ST_FREE_RUN);
	assign hold_p = sel_sec_ff || (state_ff == ST_HOLDOVER);
	assign hold_s = !sel_sec_ff || (state_ff == ST_HOLDOVER);

	tcs_dpll #(.TIMEOUT_CYC(int'(TIMEOUT_CYC))) u_dpll_pri (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_tgl(tgl_p),
		.i_period(per_p),
		.i_nominal(nominal),
		.i_range(range),
		.i_hold(hold_p),
		.i_center(center),
		.i_locked(locked),
		.o_err(err_p),
		.o_new(new_p),
		.o_in_spec(spec_p),
		.o_near(near_p),
		.o_dac(dac_p)
	);

	tcs_dpll #(.TIMEOUT_CYC(int'(TIMEOUT_CYC))) u_dpll_sec (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_tgl(tgl_s),
		.i_period(per_s),
		.i_nominal(nominal),
		.i_range(range),
		.i_hold(hold_s),
		.i_center(center),
		.i_locked(locked),
		.o_err(err_s),
		.o_new(new_s),
		.o_in_spec(spec_s),
		.o_near(near_s),
		.o_dac(dac_s)
	);

	// Reference qualification
	assign ok_p = spec_p & ~fault_s2_ff[0];
	assign ok_s = spec_s & ~fault_s2_ff[1];
	assign act_ok = sel_sec_ff ? ok_s : ok_p;
	assign oth_ok = sel_sec_ff ? ok_p : ok_s;
	assign primary_reference_source_ok = primary_reference_source_sec_ff ? ok_s : ok_p;
	assign act_near = sel_sec_ff ? near_s : near_p;
	assign both_fault = &fault_s2_ff;
	assign locked = (state_ff == ST_LOCKED);
	assign holdoff_done = (holdoff_ff == 32'h00000000);

	// Mode, stage and reference selection
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_ff <= ST_FREE_RUN;
			free_cmd_ff <= 1'b1;
			primary_reference_source_sec_ff <= 1'b0;
			sel_sec_ff <= 1'b0;
			enable_d_ff <= 1'b0;
			holdoff_ff <= 32'h00000000;
		end else if (i_ce) begin
			enable_d_ff <= enabled;
			if (!holdoff_done) begin
				holdoff_ff <= holdoff_ff - 32'h00000001;
			end
			if (!enabled || !enable_d_ff) begin
				state_ff <= ST_FREE_RUN;
				free_cmd_ff <= 1'b1;
			end else if (i_cmd_valid) begin
				if (i_cmd == CMD_TRACK_PRI || i_cmd == CMD_TRACK_SEC) begin
					primary_reference_source_sec_ff <= (i_cmd == CMD_TRACK_SEC);
					sel_sec_ff <= (i_cmd == CMD_TRACK_SEC);
					free_cmd_ff <= 1'b0;
					state_ff <= ST_TRACKING;
				end else begin
					free_cmd_ff <= 1'b1;
					state_ff <= ST_FREE_RUN;
				end
			end else if (!free_cmd_ff) begin
				if (both_fault) begin
					state_ff <= ST_FREE_RUN;
				end else if (!act_ok && oth_ok && holdoff_done && state_ff != ST_HOLDOVER) begin
					sel_sec_ff <= ~sel_sec_ff;
					holdoff_ff <= 32'(HOLDOFF_CYC);
					state_ff <= ST_TRACKING;
				end else if (!act_ok && !oth_ok) begin
					if (state_ff != ST_FREE_RUN) begin
						state_ff <= ST_HOLDOVER;
					end
				end else if (state_ff == ST_HOLDOVER || state_ff == ST_FREE_RUN) begin
					sel_sec_ff <= act_ok ? sel_sec_ff : ~sel_sec_ff;
					state_ff <= ST_TRACKING;
				end else if (sel_sec_ff != primary_reference_source_sec_ff && primary_reference_source_ok && holdoff_done) begin
					sel_sec_ff <= primary_reference_source_sec_ff;
					holdoff_ff <= 32'(HOLDOFF_CYC);
					state_ff <= ST_TRACKING;
				end else begin
					case (state_ff)
						ST_TRACKING: begin
							if (act_near) begin
								state_ff <= ST_LOCKED;
							end
						end
						ST_LOCKED: begin
							if (!act_near) begin
								state_ff <= ST_TRACKING;
							end
						end
						default: begin
							state_ff <= ST_TRACKING;
						end
					endcase
				end
			end
		end
	end

	// Indicator flash divider
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			flash_cnt_ff <= 32'h00000000;
			flash_ff <= 1'b0;
		end else if (i_ce) begin
			if (state_ff != ST_TRACKING) begin
				flash_cnt_ff <= 32'h00000000;
				flash_ff <= 1'b1;
			end else if (flash_cnt_ff >= 32'(FLASH_CYC - 1)) begin
				flash_cnt_ff <= 32'h00000000;
				flash_ff <= ~flash_ff;
			end else begin
				flash_cnt_ff <= flash_cnt_ff + 32'h00000001;
			end
		end
	end

	// Phase difference capture on firmware request
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pd_arm_ff <= 1'b0;
			phase_ff <= '0;
			pd_done_ff <= 1'b0;
		end else if (i_ce) begin
			pd_done_ff <= 1'b0;
			if (pd_arm_ff && (sel_sec_ff ? new_s : new_p)) begin
				phase_ff <= sel_sec_ff ? err_s : err_p;
				pd_done_ff <= 1'b1;
				pd_arm_ff <= i_pd_start;
			end else if (i_pd_start) begin
				pd_arm_ff <= 1'b1;
			end
		end
	end

	assign o_dac_word = center ? DAC_CENTER : (sel_sec_ff ? dac_s : dac_p);
	assign o_bp_clk = bp_clk_ff;
	assign o_tracking_mode = (state_ff != ST_FREE_RUN);
	assign o_locked = locked;
	assign o_holdover = (state_ff == ST_HOLDOVER);
	assign o_sel_secondary = sel_sec_ff;
	assign o_led_red = present & ~enabled;
	assign o_led_green = enabled & flash_ff;
	assign o_phase_diff = phase_ff;
	assign o_pd_done = pd_done_ff;
	assign o_mon_err = sel_sec_ff ? err_p : err_s;

endmodule : tcs_clock_ctrl

`default_nettype wire

// File: verilog/tcs_dpll.sv
`timescale 1ns/100ps
`default_nettype none

module tcs_dpll
	import tcs_pkg::*;
#(
	parameter int TIMEOUT_CYC = 20000
) (
	// System domain
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// From oscillator domain
	input wire logic i_tgl,
	input wire logic [CNT_W-1:0] i_period,
	// Loop control
	input wire logic [CNT_W-1:0] i_nominal,
	input wire logic [ERR_W-1:0] i_range,
	input wire logic i_hold,
	input wire logic i_center,
	input wire logic i_locked,
	// Results
	output logic signed [ERR_W-1:0] o_err,
	output logic o_new,
	output logic o_in_spec,
	output logic o_near,
	output logic [DAC_W-1:0] o_dac
);

	logic [2:0] tgl_sync_ff;
	logic signed [ERR_W-1:0] err_ff;
	logic new_ff;
	logic [31:0] age_ff;
	logic fresh_ff;
	logic [DAC_W-1:0] dac_ff;
	logic [ERR_W-1:0] mag;
	logic [DAC_W-1:0] step;

	// Toggle crossing; period word is stable long before the toggle lands
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tgl_sync_ff <= 3'h0;
		end else if (i_ce) begin
			tgl_sync_ff <= {tgl_sync_ff[1:0], i_tgl};
		end
	end

	// Error capture and freshness
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			err_ff <= '0;
			new_ff <= 1'b0;
			age_ff <= 32'h00000000;
			fresh_ff <= 1'b0;
		end else if (i_ce) begin
			new_ff <= tgl_sync_ff[1] ^ tgl_sync_ff[2];
			if (tgl_sync_ff[1] ^ tgl_sync_ff[2]) begin
				err_ff <= $signed({1'b0, i_period}) - $signed({1'b0, i_nominal});
				age_ff <= 32'h00000000;
				fresh_ff <= 1'b1;
			end else if (age_ff >= 32'(TIMEOUT_CYC)) begin
				fresh_ff <= 1'b0;
			end else begin
				age_ff <= age_ff + 32'h00000001;
			end
		end
	end

	assign mag = err_ff[ERR_W-1] ? ERR_W'(-err_ff) : err_ff;
	assign step = i_locked ? STEP_LOCK : STEP_TRACK;

	// Coarse steps while tracking, fine steps once locked
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dac_ff <= DAC_CENTER;
		end else if (i_ce) begin
			if (i_center) begin
				dac_ff <= DAC_CENTER;
			end else if (new_ff && !i_hold && err_ff != '0) begin
				if (err_ff[ERR_W-1]) begin
					dac_ff <= (dac_ff < step) ? '0 : dac_ff - step;
				end else begin
					dac_ff <= (DAC_MAX - dac_ff < step) ? DAC_MAX : dac_ff + step;
				end
			end
		end
	end

	assign o_err = err_ff;
	assign o_new = new_ff;
	assign o_in_spec = fresh_ff && (mag <= i_range);
	assign o_near = fresh_ff && (mag <= LOCK_NEAR_CNT);
	assign o_dac = dac_ff;

endmodule : tcs_dpll

`default_nettype wire

// File: verilog/tcs_ref_meter.sv
`timescale 1ns/100ps
`default_nettype none

module tcs_ref_meter
	import tcs_pkg::*;
(
	// Oscillator domain
	input wire logic i_osc_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Reference pin
	input wire logic i_ref,
	// Measurement
	output logic [CNT_W-1:0] o_period,
	output logic o_tgl
);

	logic [2:0] ref_sync_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [MEAS_EDGES_LOG2-1:0] edges_ff;
	logic [CNT_W-1:0] period_ff;
	logic tgl_ff;
	logic rise;

	// Two-stage synchroniser, third stage for the edge
	always_ff @(posedge i_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ref_sync_ff <= 3'h0;
		end else begin
			ref_sync_ff <= {ref_sync_ff[1:0], i_ref};
		end
	end

	assign rise = ref_sync_ff[1] & ~ref_sync_ff[2];

	// Oscillator cycles per window of reference edges
	always_ff @(posedge i_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_ff <= 16'h0000;
			edges_ff <= '0;
			period_ff <= 16'h0000;
			tgl_ff <= 1'b0;
		end else if (i_ce) begin
			if (cnt_ff != 16'hFFFF) begin
				cnt_ff <= cnt_ff + 16'h0001;
			end
			if (rise) begin
				edges_ff <= edges_ff + 1'b1;
				if (&edges_ff) begin
					period_ff <= cnt_ff;
					tgl_ff <= ~tgl_ff;
					cnt_ff <= 16'h0001;
				end
			end
		end
	end

	assign o_period = period_ff;
	assign o_tgl = tgl_ff;

endmodule : tcs_ref_meter

`default_nettype wire
